// ---- hw/timer_event_counter8.sv ----
// Design: 8-bit timer/event counter with preload, prescaler and AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - 8-bit up-counter, pin or prescaled clock
// - Write goes to preload, read gives counter
// - Event mode counts pin edges, timer prescaled
// - Counts from present value up to FF
// - Overflow reloads preload and sets flag
// - Pulse mode counts until pin returns, clears on
// - One pulse measurement, held until on set
// - Measurement starts only on a pin transition
// - Pulse mode overflow reloads and flags too
// - Counting only while counting-on bit set
// - Event/timer modes never clear counting-on
// - Overflow is a wake-up source from halt
// - Enable bit low blocks interrupt, flag sets
// - Write while off loads counter too
// - Count clock gated during counter reads
// - Prescaler divides by two to field power
// - Event mode edge bit: 1 falling, 0 rising
// - Pulse mode edge bit chooses start level
// - Divided output toggles on every overflow
// - Mode field 01/10/11, bit 5 reads zero
module timer_event_counter8 (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic [31:0] hrdata_o,
   input wire logic timer_pin_i,
   output logic irq_o,
   output logic wake_o,
   output logic divided_freq_output_o
);

   // Prescaler tick: low bits of the free counter all ones
   function automatic logic psc_tick(input logic [timer_event_counter8_pkg::PSC_W-1:0] cnt,
                                     input logic [2:0] sel);
      logic [timer_event_counter8_pkg::PSC_W-1:0] mask;
      mask = 7'h00;
      for (int i = 0; i < timer_event_counter8_pkg::PSC_W; i++) begin
         if (i < int'(sel)) begin
            mask[i] = 1'b1;
         end
      end
      return (cnt & mask) == mask;
   endfunction

   timer_event_counter8_pkg::tec_state_t s_r; // Registered state
   timer_event_counter8_pkg::tec_state_t s_nxt; // Next state
   logic acc; // Bus transfer taken this cycle
   logic rd_acc; // Read taken this cycle
   logic wr_count; // Count register written this cycle
   logic wr_ctrl; // Control register written this cycle
   logic wr_interrupt_control; // Interrupt control written this cycle
   logic rise; // Pin rising edge
   logic fall; // Pin falling edge
   logic int_tick; // Prescaled internal clock tick
   logic tick; // Count tick after gating
   logic ov; // Overflow this cycle
   logic pw_start; // Pulse start edge
   logic pw_stop; // Pulse stop edge
   timer_event_counter8_pkg::ctrl_t wctrl; // Control view of write data

   // Decode of bus transfer and write data phase
   always_comb begin
      acc = hsel_i && htrans_i[1] && hready_i;
      rd_acc = acc && !hwrite_i;
      wr_count = s_r.dp_write && (s_r.dp_addr == timer_event_counter8_pkg::ADDR_COUNT);
      wr_ctrl = s_r.dp_write && (s_r.dp_addr == timer_event_counter8_pkg::ADDR_CTRL);
      wr_interrupt_control = s_r.dp_write && (s_r.dp_addr == timer_event_counter8_pkg::ADDR_INTERRUPT_CONTROL);
      wctrl = timer_event_counter8_pkg::ctrl_t'(hwdata_i[7:0]);
   end

   // Edge detection and count tick selection
   always_comb begin
      rise = timer_pin_i && !s_r.pin_q;
      fall = !timer_pin_i && s_r.pin_q;
      int_tick = psc_tick(s_r.psc, s_r.ctrl.prescale_sel);
      // Edge bit 1: start rising, stop falling
      pw_start = s_r.ctrl.active_edge_select ? rise : fall;
      pw_stop = s_r.ctrl.active_edge_select ? fall : rise;
      tick = 1'b0;
      if (s_r.ctrl.counting_on) begin
         case (s_r.ctrl.mode)
            timer_event_counter8_pkg::MODE_EVENT: begin
               // Pin edges drive the counter
               tick = s_r.ctrl.active_edge_select ? fall : rise;
            end
            timer_event_counter8_pkg::MODE_TIMER: begin
               tick = int_tick;
            end
            timer_event_counter8_pkg::MODE_PULSE: begin
               // Only while a measurement runs and the stop edge is not here
               tick = int_tick && s_r.pw_active && !pw_stop;
            end
            default: begin
               tick = 1'b0;
            end
         endcase
      end
      // Block the count clock while the counter is being read
      if (rd_acc && (haddr_i[7:0] == timer_event_counter8_pkg::ADDR_COUNT)) begin
         tick = 1'b0;
      end
      ov = tick && (s_r.count == timer_event_counter8_pkg::COUNT_MAX);
   end

   // Next-state logic
   always_comb begin
      s_nxt = s_r;
      s_nxt.pin_q = timer_pin_i;
      s_nxt.psc = s_r.psc + 7'h01;
      s_nxt.wake = ov;
      // Counter advance and overflow reload
      if (ov) begin
         s_nxt.count = s_r.preload;
         s_nxt.divided_freq_output = !s_r.divided_freq_output;
      end else if (tick) begin
         s_nxt.count = s_r.count + 8'h01;
      end
      // Pulse measurement sequencing
      if (s_r.ctrl.counting_on && (s_r.ctrl.mode == timer_event_counter8_pkg::MODE_PULSE)) begin
         if (!s_r.pw_active && pw_start) begin
            s_nxt.pw_active = 1'b1;
         end else if (s_r.pw_active && pw_stop) begin
            // Measurement done, result held
            s_nxt.pw_active = 1'b0;
            s_nxt.ctrl.counting_on = 1'b0;
         end
      end else begin
         s_nxt.pw_active = 1'b0;
      end
      // Software writes in the data phase
      if (wr_count) begin
         s_nxt.preload = hwdata_i[7:0];
         if (!s_r.ctrl.counting_on) begin
            s_nxt.count = hwdata_i[7:0];
         end
      end
      if (wr_ctrl) begin
         s_nxt.ctrl = wctrl;
         s_nxt.ctrl.zero5 = 1'b0;
         s_nxt.pw_active = 1'b0;
      end
      if (wr_interrupt_control) begin
         s_nxt.ien = hwdata_i[timer_event_counter8_pkg::IEN_BIT];
         s_nxt.flag = hwdata_i[timer_event_counter8_pkg::FLAG_BIT];
      end
      // Overflow set wins over software clear
      if (ov) begin
         s_nxt.flag = 1'b1;
      end
      // Address phase capture
      s_nxt.dp_write = acc && hwrite_i;
      s_nxt.dp_addr = haddr_i[7:0];
      if (rd_acc) begin
         case (haddr_i[7:0])
            timer_event_counter8_pkg::ADDR_COUNT: begin
               s_nxt.rdata = {24'h000000, s_r.count};
            end
            timer_event_counter8_pkg::ADDR_CTRL: begin
               s_nxt.rdata = {24'h000000, s_r.ctrl};
            end
            timer_event_counter8_pkg::ADDR_INTERRUPT_CONTROL: begin
               s_nxt.rdata = 32'h00000000;
               s_nxt.rdata[timer_event_counter8_pkg::FLAG_BIT] = s_r.flag;
               s_nxt.rdata[timer_event_counter8_pkg::IEN_BIT] = s_r.ien;
            end
            default: begin
               // Unmapped reads give zero
               s_nxt.rdata = 32'h00000000;
            end
         endcase
      end
   end

   // State register, all resets give the control default
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s_r.count <= timer_event_counter8_pkg::COUNT_RST;
         s_r.preload <= timer_event_counter8_pkg::COUNT_RST;
         s_r.ctrl <= timer_event_counter8_pkg::ctrl_t'(timer_event_counter8_pkg::CTRL_RST);
         s_r.flag <= 1'b0;
         s_r.ien <= 1'b0;
         s_r.divided_freq_output <= 1'b0;
         s_r.wake <= 1'b0;
         s_r.pin_q <= 1'b0;
         s_r.psc <= timer_event_counter8_pkg::PSC_RST;
         s_r.pw_active <= 1'b0;
         s_r.dp_write <= 1'b0;
         s_r.dp_addr <= 8'h00;
         s_r.rdata <= 32'h00000000;
      end else begin
         s_r <= s_nxt;
      end
   end

   // Outputs
   assign hreadyout_o = 1'b1;
   assign hresp_o = 1'b0;
   assign hrdata_o = s_r.rdata;
   assign irq_o = s_r.flag && s_r.ien;
   assign wake_o = s_r.wake;
   assign divided_freq_output_o = s_r.divided_freq_output;

   // Checks on the counter behaviour
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Overflow reloads from the preload register
   property p_reload;
      ov && !wr_count |=> s_r.count == $past(s_r.preload);
   endproperty
   a_reload: assert property (p_reload) else $error("No reload on overflow");

   // Overflow raises the flag and a wake pulse
   property p_flag_set;
      ov |=> s_r.flag ##0 wake_o;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("Flag or wake missing");

   // Divided output moves only after an overflow
   property p_pfd_toggle;
      divided_freq_output_o != $past(divided_freq_output_o) |-> $past(ov);
   endproperty
   a_pfd_toggle: assert property (p_pfd_toggle) else $error("Divided output moved");

   // Clearing the enable bit silences the request
   property p_irq_mask;
      wr_interrupt_control && !hwdata_i[timer_event_counter8_pkg::IEN_BIT] |=> !irq_o;
   endproperty
   a_irq_mask: assert property (p_irq_mask) else $error("Masked interrupt seen");

   // Unused mode freezes the count
   property p_unused_hold;
      s_r.ctrl.mode == timer_event_counter8_pkg::MODE_UNUSED && !wr_count |=> $stable(s_r.count);
   endproperty
   a_unused_hold: assert property (p_unused_hold) else $error("Counter moved in mode 00");

   // Counter off: no movement, no wake
   property p_off_hold;
      !s_r.ctrl.counting_on && !wr_count |=> $stable(s_r.count) ##0 !s_r.wake;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("Counter moved while off");

   // Count clock held in a count read cycle
   property p_read_gate;
      rd_acc && haddr_i[7:0] == timer_event_counter8_pkg::ADDR_COUNT && !wr_count
         |=> $stable(s_r.count);
   endproperty
   a_read_gate: assert property (p_read_gate) else $error("Count during read");

   // Only software clears on outside pulse mode
   property p_on_kept;
      s_r.ctrl.counting_on && s_r.ctrl.mode != timer_event_counter8_pkg::MODE_PULSE && !wr_ctrl
         |=> s_r.ctrl.counting_on;
   endproperty
   a_on_kept: assert property (p_on_kept) else $error("Counting-on cleared by hardware");

   // Stop edge ends the measurement
   property p_pw_end;
      s_r.ctrl.counting_on && s_r.pw_active && pw_stop && !wr_ctrl
         |=> !s_r.ctrl.counting_on && !s_r.pw_active;
   endproperty
   a_pw_end: assert property (p_pw_end) else $error("Measurement did not end");

   // Control bit 5 never holds a one
   property p_bit5;
      s_r.ctrl.zero5 == 1'b0;
   endproperty
   a_bit5: assert property (p_bit5) else $error("Control bit 5 set");

   // Pin edges only start a measurement
   property p_pw_start_edge;
      s_r.ctrl.counting_on && !s_r.pw_active && timer_pin_i == s_r.pin_q |=> !s_r.pw_active;
   endproperty
   a_pw_start_edge: assert property (p_pw_start_edge) else $error("Level start");

   // A finished measurement stays finished until on is set
   property p_pw_hold;
      !s_r.ctrl.counting_on && s_r.ctrl.mode == timer_event_counter8_pkg::MODE_PULSE
         |=> !s_r.pw_active;
   endproperty
   a_pw_hold: assert property (p_pw_hold) else $error("Measurement restarted");

   // Event mode counts one per selected pin edge
   property p_event_step;
      s_r.ctrl.counting_on && s_r.ctrl.mode == timer_event_counter8_pkg::MODE_EVENT
         && (s_r.ctrl.active_edge_select ? s_r.pin_q && !timer_pin_i : timer_pin_i && !s_r.pin_q)
         && s_r.count != timer_event_counter8_pkg::COUNT_MAX && !rd_acc && !wr_count
         |=> s_r.count == $past(s_r.count) + 8'h01;
   endproperty
   a_event_step: assert property (p_event_step) else $error("Event not counted");

   // Timer at divide-by-1 counts every cycle
   property p_timer_step;
      s_r.ctrl.counting_on && s_r.ctrl.mode == timer_event_counter8_pkg::MODE_TIMER
         && s_r.ctrl.prescale_sel == 3'h0 && s_r.count != timer_event_counter8_pkg::COUNT_MAX
         && !rd_acc && !wr_count |=> s_r.count == $past(s_r.count) + 8'h01;
   endproperty
   a_timer_step: assert property (p_timer_step) else $error("Timer missed a tick");

   // Preload write while off loads both registers
   property p_load_off;
      wr_count && !s_r.ctrl.counting_on |=> s_r.count == $past(hwdata_i[7:0])
         && s_r.preload == $past(hwdata_i[7:0]);
   endproperty
   a_load_off: assert property (p_load_off) else $error("Write while off lost");

   // Preload write while on leaves the count running
   property p_load_on;
      wr_count && s_r.ctrl.counting_on && !ov |=> s_r.preload == $past(hwdata_i[7:0])
         && (s_r.count == $past(s_r.count) || s_r.count == $past(s_r.count) + 8'h01);
   endproperty
   a_load_on: assert property (p_load_on) else $error("Write while on hit count");

   // Wake pulse follows an overflow only
   property p_wake_src;
      wake_o |-> $past(ov);
   endproperty
   a_wake_src: assert property (p_wake_src) else $error("Stray wake pulse");

   // Flag stays until software writes it
   property p_flag_hold;
      s_r.flag && !wr_interrupt_control |=> s_r.flag;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("Flag lost");

   c_overflow: cover property (ov);
   c_pw_done: cover property (s_r.pw_active ##1 !s_r.ctrl.counting_on);
   c_read_gate: cover property (rd_acc && s_r.ctrl.counting_on && int_tick);
   c_write_on: cover property (wr_count && s_r.ctrl.counting_on);
   c_irq: cover property (irq_o);

endmodule

`default_nettype wire

// ---- shared/timer_event_counter8_pkg.sv ----
// Package: register map, field layouts and state record of the 8-bit timer/event counter
package timer_event_counter8_pkg;

   // Register indices, byte address is four times the index
   localparam logic [7:0] IDX_INTERRUPT_CONTROL = 8'h0B; // Interrupt control word
   localparam logic [7:0] IDX_COUNT = 8'h0D; // Count value / preload
   localparam logic [7:0] IDX_CTRL = 8'h0E; // Counter control
   localparam logic [7:0] ADDR_INTERRUPT_CONTROL = {IDX_INTERRUPT_CONTROL[5:0], 2'b00};
   localparam logic [7:0] ADDR_COUNT = {IDX_COUNT[5:0], 2'b00};
   localparam logic [7:0] ADDR_CTRL = {IDX_CTRL[5:0], 2'b00};

   // Field positions in the interrupt control word
   localparam int FLAG_BIT = 5; // Overflow request flag
   localparam int IEN_BIT = 2; // Overflow interrupt enable

   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h08;
   localparam logic [7:0] COUNT_RST = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;

   // Prescaler width, divide by up to 128
   localparam int PSC_W = 7;
   localparam logic [PSC_W-1:0] PSC_RST = 7'h00;

   // Operating mode encoding
   typedef enum logic [1:0] {
      MODE_UNUSED = 2'b00,
      MODE_EVENT = 2'b01,
      MODE_TIMER = 2'b10,
      MODE_PULSE = 2'b11
   } mode_t;

   // Counter control layout, bit 7 down to bit 0
   typedef struct packed {
      mode_t mode; // Bits 7..6
      logic zero5; // Bit 5, always zero
      logic counting_on; // Bit 4
      logic active_edge_select; // Bit 3
      logic [2:0] prescale_sel; // Bits 2..0
   } ctrl_t;

   // Whole state of the block
   typedef struct packed {
      logic [7:0] count; // Live counter
      logic [7:0] preload; // Preload register
      ctrl_t ctrl; // Control register
      logic flag; // Overflow request flag
      logic ien; // Overflow interrupt enable
      logic divided_freq_output; // Divided-frequency output
      logic wake; // Wake-up pulse
      logic pin_q; // Previous pin sample
      logic [PSC_W-1:0] psc; // Free-running prescaler
      logic pw_active; // Pulse measurement running
      logic dp_write; // Write data phase pending
      logic [7:0] dp_addr; // Address of pending write
      logic [31:0] rdata; // Read data register
   } tec_state_t;

endpackage

// ---- sim/pin_source.sv ----
// Partner model: pulse source on the external timer pin
`timescale 1ns/1ps
`default_nettype none
module pin_source (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic [7:0] n_i,
   input wire logic [7:0] hi_i,
   output logic pin_o,
   output logic busy_o
);
   int left; // Pulses still to send
   int ph; // Cycles left in this phase
   // Pin moves only just after a clock edge, low between pulses
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         left <= 0;
         ph <= 0;
         pin_o <= 1'b0;
      end else if (ph != 0) begin
         ph <= ph - 1;
      end else if (pin_o) begin
         pin_o <= 1'b0;
         ph <= 3;
      end else if (left != 0) begin
         pin_o <= 1'b1;
         left <= left - 1;
         ph <= int'(hi_i) - 1;
      end else if (start_i) begin
         left <= int'(n_i);
      end
   end
   // Busy while any pulse or gap remains
   assign busy_o = (left != 0) || pin_o || (ph != 0);
endmodule
`default_nettype wire

// ---- sim/timer_event_counter8_tb_top.sv ----
// Testbench: register, event, timer and pulse checks of the 8-bit counter
`timescale 1ns/1ps
`default_nettype none
module timer_event_counter8_tb_top;
   logic clk = 1'b0; // System clock
   logic rst_n, hsel, hwrite, hready, hresp, irq, wake, divided_freq_output, pfd_q, pin, pin_busy, pin_go;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [7:0] pin_n, pin_hi;
   logic [31:0] haddr, hwdata, hrdata, rd, lfsr;
   int error_cnt, checks_done, cyc, pfd_tg, wake_n, n, c;
   always #5 clk = ~clk;
   timer_event_counter8 dut_u (.clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(hsize), .hwdata_i(hwdata),
      .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
      .timer_pin_i(pin), .irq_o(irq), .wake_o(wake), .divided_freq_output_o(divided_freq_output));
   pin_source pin_u (.clk_i(clk), .rst_n_i(rst_n), .start_i(pin_go), .n_i(pin_n),
      .hi_i(pin_hi), .pin_o(pin), .busy_o(pin_busy));
   // Counts output toggles and wake pulses, cuts a hang short
   always @(posedge clk) begin
      cyc++;
      if (divided_freq_output !== pfd_q) pfd_tg++;
      if (wake === 1'b1) wake_n++;
      pfd_q = divided_freq_output;
      if (cyc == 40000) begin
         error_cnt++;
         summarize();
      end
   end
   // Compare and count
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One single AHB transfer: 0 interrupt_control, 1 count, 2 control, 3 unmapped
   task automatic bus(input logic w, input logic [1:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      case (a)
         2'h0: haddr <= {24'h000000, timer_event_counter8_pkg::ADDR_INTERRUPT_CONTROL};
         2'h1: haddr <= {24'h000000, timer_event_counter8_pkg::ADDR_COUNT};
         2'h2: haddr <= {24'h000000, timer_event_counter8_pkg::ADDR_CTRL};
         default: haddr <= 32'h00000040;
      endcase
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Ask the pin source for k pulses, wait until the last edge is counted
   task automatic pulses(input int k, input int hi);
      pin_n <= 8'(k);
      pin_hi <= 8'(hi);
      pin_go <= 1'b1;
      @(posedge clk);
      pin_go <= 1'b0;
      @(posedge clk);
      while (pin_busy) @(posedge clk);
      repeat (3) @(posedge clk);
   endtask
   // Event counter model, preload FC
   function automatic int ev(input int s, input int k);
      for (int i = 0; i < k; i++) s = (s == 255) ? 252 : s + 1;
      return s;
   endfunction
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic done(input string s);
      $display("test %s done", s);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      rst_n = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      htrans = 2'h0;
      hsize = 3'h2;
      haddr = 32'h00000000;
      hwdata = 32'h00000000;
      pin_go = 1'b0;
      pin_n = 8'h00;
      pin_hi = 8'h00;
      lfsr = 32'h0001864E;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'h08);
      bus(1'b0, 2'h3, 32'h0);
      chk(rd, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      done("reset");
      // Event mode, rising then falling edges
      for (int e = 0; e < 2; e++) begin
         lfsr = nxt(lfsr);
         n = 4 + int'(lfsr[1:0]);
         bus(1'b1, 2'h0, 32'h0);
         bus(1'b1, 2'h2, 32'h40 | 32'(e * 8));
         bus(1'b1, 2'h1, 32'hFC);
         pfd_tg = 0;
         wake_n = 0;
         bus(1'b1, 2'h2, 32'h50 | 32'(e * 8));
         pulses(n, 2);
         c = ev(252, n);
         bus(1'b0, 2'h1, 32'h0);
         chk(rd, 32'(c));
         chk(32'(pfd_tg), 32'h1);
         chk(32'(wake_n), 32'h1);
         bus(1'b0, 2'h2, 32'h0);
         chk(rd, 32'h50 | 32'(e * 8));
         bus(1'b0, 2'h0, 32'h0);
         chk({31'h0, rd[5]}, 32'h1);
         chk({31'h0, irq}, 32'h0);
         bus(1'b1, 2'h0, 32'h24);
         @(posedge clk);
         chk({31'h0, irq}, 32'h1);
         bus(1'b1, 2'h1, 32'h10);
         bus(1'b0, 2'h1, 32'h0);
         chk(rd, 32'(c));
         pulses(256 - c, 2);
         bus(1'b0, 2'h1, 32'h0);
         chk(rd, 32'h10);
         done("event");
      end
      // Timer mode, every prescale code, overflow on every tick
      for (int p = 0; p < 8; p++) begin
         bus(1'b1, 2'h2, 32'h80 | 32'(p));
         bus(1'b1, 2'h1, 32'hFF);
         pfd_tg = 0;
         bus(1'b1, 2'h2, 32'h90 | 32'(p));
         repeat (1024) @(posedge clk);
         n = pfd_tg - (1024 >> p);
         chk(32'(n >= -2 && n <= 2), 32'h1);
      end
      // Two reads of a running count, each read holds one tick back
      bus(1'b1, 2'h2, 32'h80);
      bus(1'b1, 2'h1, 32'h0);
      bus(1'b1, 2'h2, 32'h90);
      bus(1'b0, 2'h1, 32'h0);
      c = int'(rd[7:0]);
      bus(1'b0, 2'h1, 32'h0);
      n = int'(rd[7:0]) - c;
      chk(32'(n), 32'h1);
      done("timer");
      // Pulse mode, one high pulse measured across an overflow, then held
      bus(1'b1, 2'h2, 32'hC8);
      bus(1'b1, 2'h1, 32'hF0);
      bus(1'b1, 2'h0, 32'h0);
      bus(1'b1, 2'h2, 32'hD8);
      pulses(1, 20);
      bus(1'b0, 2'h1, 32'h0);
      c = int'(rd[7:0]);
      chk(32'(rd >= 32'hF3 && rd <= 32'hF5), 32'h1);
      bus(1'b0, 2'h0, 32'h0);
      chk({31'h0, rd[5]}, 32'h1);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'hC8);
      pulses(1, 9);
      bus(1'b0, 2'h1, 32'h0);
      chk(rd, 32'(c));
      // Low pulse, pin already low at enable must not start
      bus(1'b1, 2'h2, 32'hC0);
      bus(1'b1, 2'h1, 32'h0);
      bus(1'b1, 2'h2, 32'hD0);
      pulses(2, 3);
      bus(1'b0, 2'h1, 32'h0);
      chk(32'(rd >= 3 && rd <= 5), 32'h1);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'hC0);
      done("pulse");
      // Unused mode holds the count
      bus(1'b1, 2'h2, 32'h08);
      bus(1'b1, 2'h1, 32'h33);
      bus(1'b1, 2'h2, 32'h18);
      pulses(3, 2);
      bus(1'b0, 2'h1, 32'h0);
      chk(rd, 32'h33);
      done("unused");
      // Reset in mid-run restores the control default
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      bus(1'b0, 2'h2, 32'h0);
      chk(rd, 32'h08);
      done("reset again");
      summarize();
   end
endmodule
`default_nettype wire
